// ===== hw/ulac_core.sv
// Activation, deactivation and command/indicate control of the line side
`timescale 1ns/1ps
`default_nettype none
`include "ulac_cfg.svh"
module ulac_core #(
   parameter int PULSE_CYC = `ULAC_PULSE_CYC,    // 1 ms in clocks
   parameter int STAY_CYC  = `ULAC_MIN_STAY_CYC  // 0.5 ms in clocks
) (
   input  wire logic       clk_i,            // 125 MHz system clock
   input  wire logic       rst_i,            // Asynchronous reset, active high
   input  wire logic       hwy_clk_i,        // Highway bit clock from outside
   input  wire logic       hwy_frame_i,      // Highway frame sync from outside
   input  wire logic [3:0] cmd_code_i,       // Command code on the highway
   input  wire logic       upstream_data_line_i, // Upstream data line level
   input  wire logic       reset_n_i,        // Reset pin, active low
   input  wire logic       por_i,            // Power-on or undervoltage
   input  wire logic       test_select_0_i,  // Test select pin 0
   input  wire logic       test_select_1_i,  // Test select pin 1
   input  wire logic       line_frame_i,     // Line frame strobe from receiver
   input  wire logic       descr_bit_vld_i,  // Descrambler output bit valid
   input  wire logic       descr_bit_i,      // Descrambler output bit
   input  wire logic       descr_binary_i,   // Descrambler sees binary data
   input  wire logic       line_zero_i,      // Receive level is zero
   input  wire logic       m_sym_vld_i,      // Maintenance symbol valid
   input  wire logic       m_sym_plus_i,     // Symbol has plus polarity
   input  wire logic       m_sym_zero_i,     // Symbol has zero polarity
   input  wire logic       frame_word_ok_i,  // Frame word found at position
   input  wire logic       awake_ack_i,      // Exchange awake signal seen
   output logic [3:0]      ind_code_o,       // Indication code on highway
   output logic [2:0]      line_tx_o,        // Line signal selection
   output logic            single_pulse_o,   // One-cycle single line pulse
   output logic            clamp_dd_o,       // Force downstream user bits high
   output logic            hwy_clk_en_o,     // Highway clocks running
   output logic            powered_up_o      // Internal circuits powered
);
   // Synchronised highway, pin and line inputs
   logic [3:0] cmd_s;
   logic       hclk_s, hfr_s, du_s, rstn_s, por_s, ts0_s, ts1_s;
   logic       lfr_s, bv_s, bit_s, bin_s, zero_s, mv_s, mp_s, mz_s, fw_s, ack_s;
   logic [2:0] unused3;   // Spare synchroniser bits
   // Main state, read by the detectors below, and its next value
   ulac_pkg::ulac_state_t state_r, state_nxt;
   ulac_sync #(.W(24)) u_sync (
      .clk_i     (clk_i),
      .rst_i     (rst_i),
      .d_i       ({cmd_code_i, hwy_clk_i, hwy_frame_i, upstream_data_line_i,
                   reset_n_i, por_i, test_select_0_i, test_select_1_i,
                   line_frame_i, descr_bit_vld_i, descr_bit_i, descr_binary_i,
                   line_zero_i, m_sym_vld_i, m_sym_plus_i, m_sym_zero_i,
                   frame_word_ok_i, awake_ack_i, 3'h0}),
      .rst_val_i (24'h000000),
      .q_o       ({cmd_s, hclk_s, hfr_s, du_s, rstn_s, por_s, ts0_s, ts1_s,
                   lfr_s, bv_s, bit_s, bin_s, zero_s, mv_s, mp_s, mz_s,
                   fw_s, ack_s, unused3})
   );

   // Edge finders on the synchronised strobes
   logic hclk_d_r, lfr_d_r, bv_d_r, mv_d_r;
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         hclk_d_r <= 1'b0;
         lfr_d_r  <= 1'b0;
         bv_d_r   <= 1'b0;
         mv_d_r   <= 1'b0;
      end else begin
         hclk_d_r <= hclk_s;
         lfr_d_r  <= lfr_s;
         bv_d_r   <= bv_s;
         mv_d_r   <= mv_s;
      end
   end
   logic hfr_evt, lfr_evt, bit_evt, m_evt;
   // Highway frame taken on a rising highway clock edge with frame sync high
   // Frame sync is a level here: the two pins are synchronised apart, so their
   // edges need not land in the same cycle even when they move together
   assign hfr_evt = hclk_s & ~hclk_d_r & hfr_s;
   assign lfr_evt = lfr_s & ~lfr_d_r;
   assign bit_evt = bv_s & ~bv_d_r;
   assign m_evt   = mv_s & ~mv_d_r;

   // Double last look on the command code
   logic [3:0] cmd_last_r;
   logic [3:0] cmd_r;       // Accepted command
   logic       cmd_new_r;   // One-cycle pulse per accepted frame
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         cmd_last_r <= `ULAC_CMD_DI;
         cmd_r      <= `ULAC_CMD_DI;
         cmd_new_r  <= 1'b0;
      end else begin
         cmd_new_r <= 1'b0;
         if (hfr_evt) begin
            cmd_last_r <= cmd_s;
            if (cmd_s == cmd_last_r) begin
               cmd_r     <= cmd_s;
               cmd_new_r <= 1'b1;
            end
         end
      end
   end

   // Decode of the accepted command
   function automatic logic is_cmd(input logic [3:0] c, input logic [3:0] k);
      is_cmd = (c == k);
   endfunction
   logic c_res, c_ssp, c_ar, c_ai, c_di, c_tim;
   assign c_res = is_cmd(cmd_r, `ULAC_CMD_RES);
   assign c_ssp = is_cmd(cmd_r, `ULAC_CMD_SSP);
   assign c_ar  = is_cmd(cmd_r, `ULAC_CMD_AR);
   assign c_ai  = is_cmd(cmd_r, `ULAC_CMD_AI);
   assign c_di  = is_cmd(cmd_r, `ULAC_CMD_DI);
   assign c_tim = is_cmd(cmd_r, `ULAC_CMD_TIM);

   // Reset and test pin conditions
   logic pin_res, pin_ssp, ssp_any, res_any;
   assign pin_res = ~rstn_s | por_s;
   assign pin_ssp = ts0_s & ~ts1_s;
   assign ssp_any = c_ssp | pin_ssp;
   assign res_any = c_res | pin_res;

   // Exchange sync signal: binary data for 9 line frames
   logic [3:0] sync_cnt_r;
   logic       sync_det_r;
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         sync_cnt_r <= 4'h0;
         sync_det_r <= 1'b0;
      end else if (lfr_evt) begin
         if (!bin_s) begin
            sync_cnt_r <= 4'h0;
            sync_det_r <= 1'b0;
         end else if (sync_cnt_r != `ULAC_SYNC_FRAMES) begin
            sync_cnt_r <= sync_cnt_r + 4'h1;
         end else begin
            sync_det_r <= 1'b1;
         end
      end
   end

   // Transparent signal: 16 consecutive ones
   logic [4:0] ones_cnt_r;
   logic       transp_det_r;
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         ones_cnt_r   <= 5'h00;
         transp_det_r <= 1'b0;
      end else if (bit_evt) begin
         if (!bit_s) begin
            ones_cnt_r   <= 5'h00;
            transp_det_r <= 1'b0;
         end else if (ones_cnt_r + 5'h01 >= `ULAC_ONES_RUN) begin
            transp_det_r <= 1'b1;
            ones_cnt_r   <= `ULAC_ONES_RUN;
         end else begin
            ones_cnt_r <= ones_cnt_r + 5'h01;
         end
      end
   end

   // Line silence: a whole line frame at zero level
   logic frame_zero_r, silence_r;
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         frame_zero_r <= 1'b1;
         silence_r    <= 1'b0;
      end else if (lfr_evt) begin
         silence_r    <= frame_zero_r & zero_s;
         frame_zero_r <= 1'b1;
      end else if (!zero_s) begin
         frame_zero_r <= 1'b0;
      end
   end

   // Maintenance symbol runs choose the loop variants
   logic [3:0] mplus_r, mzero_r;
   logic       loop_r;
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         mplus_r <= 4'h0;
         mzero_r <= 4'h0;
         loop_r  <= 1'b0;
      end else if (state_r == ulac_pkg::ST_DEACT_REQ || state_r == ulac_pkg::ST_POWER_DOWN) begin
         loop_r  <= 1'b0; // Loop opens at deactivation
         mplus_r <= 4'h0;
         mzero_r <= 4'h0;
      end else if (m_evt) begin
         mplus_r <= mp_s ? mplus_r + {3'h0, mplus_r != `ULAC_M_RUN} : 4'h0;
         mzero_r <= mz_s ? mzero_r + {3'h0, mzero_r != `ULAC_M_RUN} : 4'h0;
         if (mp_s && mplus_r == `ULAC_M_RUN - 4'h1)
            loop_r <= 1'b1;
         if (mz_s && mzero_r == `ULAC_M_RUN - 4'h1)
            loop_r <= 1'b0;
      end
   end

   // Frame word tracking in data transmission
   logic [6:0] lost_cnt_r;
   logic [2:0] found_cnt_r;
   logic       resync_r;
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         lost_cnt_r  <= 7'h00;
         found_cnt_r <= 3'h0;
         resync_r    <= 1'b0;
      end else if (state_r != ulac_pkg::ST_DATA) begin
         lost_cnt_r  <= 7'h00;
         found_cnt_r <= 3'h0;
         resync_r    <= 1'b0;
      end else if (lfr_evt) begin
         if (fw_s) begin
            lost_cnt_r <= 7'h00;
            if (found_cnt_r == `ULAC_FOUND_FRAMES - 3'h1)
               resync_r <= 1'b0;
            else
               found_cnt_r <= found_cnt_r + 3'h1;
         end else begin
            found_cnt_r <= 3'h0;
            if (lost_cnt_r == `ULAC_LOST_FRAMES - 7'h01)
               resync_r <= 1'b1;
            else
               lost_cnt_r <= lost_cnt_r + 7'h01;
         end
      end
   end

   // Main state machine and minimum-stay timer
   logic [31:0] stay_r;
   logic        stay_done;
   assign stay_done = (stay_r == 32'h0);
   always_comb begin
      state_nxt = state_r;
      case (state_r)
         ulac_pkg::ST_POWER_DOWN:
            if (c_ar) state_nxt = ulac_pkg::ST_START_AWAKE;
            else if (!du_s) state_nxt = ulac_pkg::ST_HWY_AWAKE;
         ulac_pkg::ST_HWY_AWAKE:
            if (c_ar) state_nxt = ulac_pkg::ST_START_AWAKE;
            else if (c_di && stay_done) state_nxt = ulac_pkg::ST_POWER_DOWN;
         ulac_pkg::ST_START_AWAKE: if (ack_s) state_nxt = ulac_pkg::ST_SYNCING;
         ulac_pkg::ST_SYNCING: if (sync_det_r) state_nxt = ulac_pkg::ST_S_SYNCING;
         ulac_pkg::ST_S_SYNCING: if (c_ai) state_nxt = ulac_pkg::ST_WAIT_TRANSP;
         ulac_pkg::ST_WAIT_TRANSP: if (transp_det_r) state_nxt = ulac_pkg::ST_DATA;
         ulac_pkg::ST_DATA: state_nxt = ulac_pkg::ST_DATA;
         ulac_pkg::ST_DEACT_REQ:
            if (c_di && stay_done && !ssp_any && !res_any)
               state_nxt = ulac_pkg::ST_DEACTIVATE;
         ulac_pkg::ST_DEACTIVATE: if (stay_done) state_nxt = ulac_pkg::ST_POWER_DOWN;
         default: state_nxt = ulac_pkg::ST_DEACT_REQ;
      endcase
      if (silence_r && state_r != ulac_pkg::ST_POWER_DOWN
          && state_r != ulac_pkg::ST_HWY_AWAKE && state_r != ulac_pkg::ST_DEACT_REQ
          && state_r != ulac_pkg::ST_DEACTIVATE)
         state_nxt = ulac_pkg::ST_DEACT_REQ;
      if (res_any || ssp_any)
         state_nxt = ulac_pkg::ST_DEACT_REQ;
   end
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         state_r <= ulac_pkg::ST_DEACT_REQ;
         stay_r  <= 32'(STAY_CYC);
      end else begin
         state_r <= state_nxt;
         if (state_nxt != state_r || res_any || ssp_any)
            stay_r <= 32'(STAY_CYC);
         else if (!stay_done)
            stay_r <= stay_r - 32'h1;
      end
   end

   // Single pulse period timer
   logic [31:0] pulse_r;
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         pulse_r        <= 32'h0;
         single_pulse_o <= 1'b0;
      end else if (state_r == ulac_pkg::ST_DEACT_REQ && ssp_any) begin
         single_pulse_o <= (pulse_r == 32'h0);
         pulse_r <= (pulse_r == 32'h0) ? 32'(PULSE_CYC - 1) : pulse_r - 32'h1;
      end else begin
         pulse_r        <= 32'h0;
         single_pulse_o <= 1'b0;
      end
   end

   // Indication code, line signal and clamp
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         ind_code_o <= `ULAC_IND_DR;
         line_tx_o  <= ulac_pkg::TX_SILENCE;
         clamp_dd_o <= 1'b1;
      end else begin
         clamp_dd_o <= (state_nxt != ulac_pkg::ST_DATA);
         case (state_nxt)
            ulac_pkg::ST_START_AWAKE: begin
               ind_code_o <= `ULAC_IND_DR;
               line_tx_o  <= ulac_pkg::TX_AWAKE;
            end
            ulac_pkg::ST_SYNCING: begin
               ind_code_o <= `ULAC_IND_DR;
               line_tx_o  <= ulac_pkg::TX_AWAKE;
            end
            ulac_pkg::ST_S_SYNCING: begin
               ind_code_o <= loop_r ? `ULAC_IND_ARL : `ULAC_IND_AR;
               line_tx_o  <= ulac_pkg::TX_AWAKE;
            end
            ulac_pkg::ST_WAIT_TRANSP: begin
               ind_code_o <= loop_r ? `ULAC_IND_ARL : `ULAC_IND_AR;
               line_tx_o  <= ulac_pkg::TX_SYNCED;
            end
            ulac_pkg::ST_DATA: begin
               ind_code_o <= resync_r ? `ULAC_IND_RSY :
                             (loop_r ? `ULAC_IND_AIL : `ULAC_IND_AI);
               line_tx_o  <= ulac_pkg::TX_DATA;
            end
            ulac_pkg::ST_DEACT_REQ: begin
               ind_code_o <= `ULAC_IND_DR;
               line_tx_o  <= ssp_any ? ulac_pkg::TX_PULSES : ulac_pkg::TX_SILENCE;
            end
            ulac_pkg::ST_DEACTIVATE: begin
               ind_code_o <= `ULAC_IND_DR;
               line_tx_o  <= ulac_pkg::TX_SILENCE;
            end
            default: begin
               ind_code_o <= `ULAC_IND_DC;
               line_tx_o  <= ulac_pkg::TX_SILENCE;
            end
         endcase
      end
   end

   // Highway power-down after confirmation and clock stop after notices
   logic [2:0] dc_frm_r, di_cnt_r;
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         dc_frm_r     <= 3'h0;
         di_cnt_r     <= 3'h0;
         hwy_clk_en_o <= 1'b1;
         powered_up_o <= 1'b1;
      end else if (state_r == ulac_pkg::ST_POWER_DOWN) begin
         powered_up_o <= 1'b0;
         if (hfr_evt && dc_frm_r != `ULAC_HWY_OFF_FRAMES)
            dc_frm_r <= dc_frm_r + 3'h1;
         if (cmd_new_r && c_di && di_cnt_r != `ULAC_DI_COUNT)
            di_cnt_r <= di_cnt_r + 3'h1;
         if (di_cnt_r == `ULAC_DI_COUNT && dc_frm_r == `ULAC_HWY_OFF_FRAMES)
            hwy_clk_en_o <= 1'b0;
         if (!du_s || c_tim)
            hwy_clk_en_o <= 1'b1;
      end else begin
         dc_frm_r     <= 3'h0;
         di_cnt_r     <= 3'h0;
         hwy_clk_en_o <= 1'b1;
         powered_up_o <= (state_r != ulac_pkg::ST_HWY_AWAKE);
      end
   end

   // Checks
   rst_dr_a: assert property (@(posedge clk_i) disable iff (rst_i)
      res_any |=> ind_code_o == `ULAC_IND_DR) else $error("reset not DR");
   clamp_a: assert property (@(posedge clk_i) disable iff (rst_i)
      state_r != ulac_pkg::ST_DATA && $stable(state_r) |-> clamp_dd_o)
      else $error("user bits not clamped");
   ssp_tx_a: assert property (@(posedge clk_i) disable iff (rst_i)
      ssp_any && state_r == ulac_pkg::ST_DEACT_REQ |=> line_tx_o == ulac_pkg::TX_PULSES)
      else $error("no pulses");
   deact_stay_a: assert property (@(posedge clk_i) disable iff (rst_i)
      state_r == ulac_pkg::ST_DEACTIVATE && !stay_done |=> state_r != ulac_pkg::ST_POWER_DOWN)
      else $error("left deactivating early");
   dr_stay_a: assert property (@(posedge clk_i) disable iff (rst_i)
      state_r == ulac_pkg::ST_DEACT_REQ && !stay_done |=> state_r != ulac_pkg::ST_DEACTIVATE)
      else $error("accepted notice early");
   ar_wake_a: assert property (@(posedge clk_i) disable iff (rst_i)
      state_r == ulac_pkg::ST_POWER_DOWN && c_ar && !res_any && !ssp_any ##1 1 |=>
      line_tx_o == ulac_pkg::TX_AWAKE) else $error("no awake signal");
   cmd_acc_a: assert property (@(posedge clk_i) disable iff (rst_i)
      cmd_new_r |-> cmd_r == $past(cmd_last_r)) else $error("bad accept");
   resync_a: assert property (@(posedge clk_i) disable iff (rst_i)
      resync_r && state_r == ulac_pkg::ST_DATA && state_nxt == ulac_pkg::ST_DATA |=>
      ind_code_o == `ULAC_IND_RSY) else $error("no resync");
endmodule // ulac_core
`default_nettype wire

// ===== hw/ulac_cfg.svh
// Timing counts and code values for the line activation control block
`ifndef ULAC_CFG_SVH
`define ULAC_CFG_SVH
`define ULAC_CLK_MHZ          125
`define ULAC_PULSE_PERIOD_US  1000
`define ULAC_PULSE_CYC        (`ULAC_PULSE_PERIOD_US * `ULAC_CLK_MHZ)
`define ULAC_MIN_STAY_US      500
`define ULAC_MIN_STAY_CYC     (`ULAC_MIN_STAY_US * `ULAC_CLK_MHZ)
`define ULAC_SYNC_FRAMES      4'd8
`define ULAC_ONES_RUN         5'd16
`define ULAC_M_RUN            4'd8
`define ULAC_LOST_FRAMES      7'd64
`define ULAC_FOUND_FRAMES     3'd4
`define ULAC_HWY_OFF_FRAMES   3'd4
`define ULAC_DI_COUNT         3'd4
`define ULAC_CMD_TIM          4'h0
`define ULAC_CMD_SSP          4'h5
`define ULAC_CMD_AR           4'h8
`define ULAC_CMD_AI           4'hC
`define ULAC_CMD_RES          4'hD
`define ULAC_CMD_DI           4'hF
`define ULAC_IND_DR           4'h0
`define ULAC_IND_RSY          4'h4
`define ULAC_IND_AR           4'h8
`define ULAC_IND_ARL          4'hA
`define ULAC_IND_AI           4'hC
`define ULAC_IND_AIL          4'hE
`define ULAC_IND_DC           4'hF
`endif

// ===== hw/ulac_pkg.sv
// Types shared by the line activation control block
`default_nettype none
package ulac_pkg;
   // Activation states, Gray coded along the usual path
   typedef enum logic [3:0] {
      ST_POWER_DOWN  = 4'h0,
      ST_START_AWAKE = 4'h1,
      ST_SYNCING     = 4'h3,
      ST_S_SYNCING   = 4'h2,
      ST_WAIT_TRANSP = 4'h6,
      ST_DATA        = 4'h7,
      ST_DEACT_REQ   = 4'h5,
      ST_DEACTIVATE  = 4'h4,
      ST_HWY_AWAKE   = 4'hC
   } ulac_state_t;
   // Line signal selection toward the exchange
   typedef enum logic [2:0] {
      TX_SILENCE = 3'h0,
      TX_AWAKE   = 3'h1,
      TX_SYNCED  = 3'h2,
      TX_DATA    = 3'h3,
      TX_PULSES  = 3'h4
   } ulac_tx_t;
endpackage
`default_nettype wire

// ===== hw/ulac_sync.sv
// Two flip-flop synchroniser for signals from outside the clock domain
`timescale 1ns/1ps
`default_nettype none
module ulac_sync #(
   parameter int W = 1
) (
   input  wire logic         clk_i,
   input  wire logic         rst_i,
   input  wire logic [W-1:0] d_i,
   input  wire logic [W-1:0] rst_val_i,
   output logic      [W-1:0] q_o
);
   logic [W-1:0] meta_r;  // First stage, read only by the second
   // Two stages; reset value is a constant zero
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         meta_r <= '0;
         q_o    <= '0;
      end else begin
         meta_r <= d_i;
         q_o    <= meta_r;
      end
   end
   // rst_val_i kept for callers needing a documented idle level; unused here
   logic unused_w;
   assign unused_w = ^rst_val_i;
endmodule // ulac_sync
`default_nettype wire

// ===== tb/ulac_s_side.sv
// Behavioural companion transceiver on the framed highway
`timescale 1ns/1ps
`default_nettype none
module ulac_s_side (
   output logic       hwy_clk_o,   // Highway clock, still between send calls
   output logic       hwy_frame_o, // Frame sync, high in the first bit
   output logic [3:0] cmd_code_o,  // Command code slot
   output logic       du_o         // Upstream data line, pulled high
);
   // Idle: no clock, undefined code, line at its pull-up
   initial begin
      hwy_clk_o   = 1'b0;
      hwy_frame_o = 1'b0;
      cmd_code_o  = 4'h3;
      du_o        = 1'b1;
   end
   // Sends one code in n frames of 8 highway bits at 64 ns each
   task automatic send(input logic [3:0] code, input int n);
      repeat (n) begin
         cmd_code_o  = code;
         hwy_frame_o = 1'b1;
         // Frame sync covers only the first bit
         #32 hwy_clk_o = 1'b1;
         #32 hwy_clk_o = 1'b0;
         hwy_frame_o = 1'b0;
         repeat (7) begin
            #32 hwy_clk_o = 1'b1;
            #32 hwy_clk_o = 1'b0;
         end
      end
      // Released slot shows the inverse, never a stale match; the gap keeps
      // the next call from driving the slot again in the same time step
      #32 cmd_code_o = ~code;
   endtask
   // Asks for timing by holding the upstream line low
   task automatic wake(input int ns);
      du_o = 1'b0;
      #(ns);
      du_o = 1'b1;
   endtask
endmodule // ulac_s_side
`default_nettype wire

// ===== tb/tb.sv
// Self-checking bench for the line activation control block
`timescale 1ns/1ps
`default_nettype none
module tb;
   logic clk_i, rst_i, hck, hfr, du, reset_n_i, por_i, ts0, ts1;
   logic line_frame_i, descr_bit_vld_i, m_sym_vld_i, word_ok, bin, ack;
   logic [3:0] cmd, ind;
   logic [2:0] ltx;
   logic pulse, clamp, hwy_en, pwr;
   logic dbit, lzero, mplus, mzero;  // Data bit, line level, symbol polarity
   int n_mismatch, checked, cnt;
   ulac_s_side PARTNER (.hwy_clk_o(hck), .hwy_frame_o(hfr), .cmd_code_o(cmd), .du_o(du));
   // Short counts keep the run brief; expectations use the same values
   ulac_core #(.PULSE_CYC(50), .STAY_CYC(400)) DUT (
      .clk_i(clk_i), .rst_i(rst_i), .hwy_clk_i(hck), .hwy_frame_i(hfr),
      .cmd_code_i(cmd), .upstream_data_line_i(du), .reset_n_i(reset_n_i),
      .por_i(por_i), .test_select_0_i(ts0), .test_select_1_i(ts1),
      .line_frame_i(line_frame_i), .descr_bit_vld_i(descr_bit_vld_i),
      .descr_bit_i(dbit), .descr_binary_i(bin), .line_zero_i(lzero),
      .m_sym_vld_i(m_sym_vld_i), .m_sym_plus_i(mplus), .m_sym_zero_i(mzero),
      .frame_word_ok_i(word_ok), .awake_ack_i(ack), .ind_code_o(ind),
      .line_tx_o(ltx), .single_pulse_o(pulse), .clamp_dd_o(clamp),
      .hwy_clk_en_o(hwy_en), .powered_up_o(pwr));
   // 125 MHz system clock
   initial begin
      clk_i = 1'b0;
      forever #4 clk_i = ~clk_i;
   end
   // Waits n edges, then steps just past the edge
   task automatic cyc(input int n);
      repeat (n) @(posedge clk_i);
      #1;
   endtask
   // Strobes: 0 line frame, 1 descrambled bit, 2 maintenance symbol
   task automatic pul(input int k, input int n);
      repeat (n) begin
         case (k)
            0: line_frame_i = 1'b1;
            1: descr_bit_vld_i = 1'b1;
            default: m_sym_vld_i = 1'b1;
         endcase
         cyc(4);
         {line_frame_i, descr_bit_vld_i, m_sym_vld_i} = 3'h0;
         cyc(4);
      end
   endtask
   // Compares one code or flag, padded to four bits
   task automatic chk(input string nm, input logic [3:0] e, input logic [3:0] g);
      checked++;
      if (g !== e) begin
         n_mismatch++;
         $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
      end
   endtask
   // Verdict and end of run
   task automatic conclude();
      $display("mismatches %0d comparisons %0d", n_mismatch, checked);
      if (n_mismatch == 0 && checked > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   // Reset defaults at the outputs
   task automatic t_reset();
      chk("ind", 4'h0, ind);
      chk("tx", 4'h0, {1'b0, ltx});
      chk("clamp", 4'h1, {3'h0, clamp});
   endtask
   // Full activation through to data with loop selected
   task automatic t_activate();
      // Reset leaves a deactivation notice standing: two 400-cycle stays to power down
      cyc(820);
      chk("ind dc start", 4'hF, ind);
      chk("pwr start", 4'h0, {3'h0, pwr});
      PARTNER.send(4'h8, 1);
      PARTNER.send(4'h3, 1);
      cyc(10);
      chk("tx one frame", 4'h0, {1'b0, ltx});
      PARTNER.send(4'h8, 2);
      cyc(10);
      chk("tx awake", 4'h1, {1'b0, ltx});
      chk("pwr", 4'h1, {3'h0, pwr});
      ack = 1'b1;
      bin = 1'b1;
      pul(2, 8);
      pul(0, 7);
      chk("ind early", 4'h0, ind);
      pul(0, 2);
      chk("ind arl", 4'hA, ind);
      PARTNER.send(4'hC, 2);
      cyc(10);
      chk("tx synced", 4'h2, {1'b0, ltx});
      pul(1, 15);
      chk("ind no ail", 4'hA, ind);
      chk("clamp act", 4'h1, {3'h0, clamp});
      pul(1, 1);
      chk("ind ail", 4'hE, ind);
      chk("tx data", 4'h3, {1'b0, ltx});
      chk("clamp data", 4'h0, {3'h0, clamp});
   endtask
   // Lost frame word for 64 frames, then found in 4
   task automatic t_resync();
      word_ok = 1'b0;
      pul(0, 63);
      chk("ind 63", 4'hE, ind);
      pul(0, 1);
      chk("ind rsy", 4'h4, ind);
      word_ok = 1'b1;
      pul(0, 3);
      chk("ind still rsy", 4'h4, ind);
      pul(0, 1);
      chk("ind found", 4'hE, ind);
      // Zero level: a partial frame is not silence, a whole one is
      lzero = 1'b1;
      pul(0, 1);
      chk("ind part zero", 4'hE, ind);
      pul(0, 1);
      chk("ind silence", 4'h0, ind);
      chk("clamp silence", 4'h1, {3'h0, clamp});
      lzero = 1'b0;
   endtask
   // Pulse command with period, then reset command
   task automatic t_pulses();
      PARTNER.send(4'h5, 2);
      cyc(10);
      chk("tx pulses", 4'h4, {1'b0, ltx});
      chk("ind dr", 4'h0, ind);
      for (cnt = 0; cnt < 200 && pulse !== 1'b1; cnt++) cyc(1);
      cyc(1);
      for (cnt = 1; cnt < 200 && pulse !== 1'b1; cnt++) cyc(1);
      chk("period", 4'h2, (cnt == 50) ? 4'h2 : 4'hF);
      PARTNER.send(4'hD, 2);
      cyc(10);
      chk("tx silent", 4'h0, {1'b0, ltx});
      chk("clamp", 4'h1, {3'h0, clamp});
   endtask
   // Test pins force pulses; pin reset silences
   task automatic t_pins();
      ts0 = 1'b1;
      cyc(10);
      chk("tx pin", 4'h4, {1'b0, ltx});
      chk("ind pin", 4'h0, ind);
      ts0 = 1'b0;
      reset_n_i = 1'b0;
      cyc(10);
      chk("tx rst pin", 4'h0, {1'b0, ltx});
      reset_n_i = 1'b1;
      cyc(4);
   endtask
   // Early notice refused, then deactivate, stop clocks, wake
   task automatic t_deact();
      PARTNER.send(4'hD, 2);
      PARTNER.send(4'hF, 3);
      cyc(4);
      chk("ind hold", 4'h0, ind);
      PARTNER.send(4'hF, 30);
      cyc(10);
      chk("ind dc", 4'hF, ind);
      chk("hwy off", 4'h0, {3'h0, hwy_en});
      chk("pwr off", 4'h0, {3'h0, pwr});
      PARTNER.wake(400);
      cyc(10);
      chk("hwy on", 4'h1, {3'h0, hwy_en});
   endtask
   // Main sequence
   initial begin
      {rst_i, reset_n_i, ts1, word_ok, dbit, mplus} = 6'h3F;
      {por_i, ts0, line_frame_i, descr_bit_vld_i, m_sym_vld_i, bin, ack, lzero, mzero} = 9'h000;
      n_mismatch = 0;
      checked = 0;
      cyc(4);
      rst_i = 1'b0;
      ts1 = 1'b0;
      cyc(3);
      t_reset();
      t_activate();
      t_resync();
      t_pulses();
      t_pins();
      t_deact();
      conclude();
   end
   // Watchdog against a hang
   initial begin
      #200000;
      n_mismatch++;
      conclude();
   end
endmodule // tb
`default_nettype wire
